// file: core/dmrs_top.sv
`timescale 1ns/1ns
`default_nettype none
// Purpose: Mode register, reference choice register and loop state for a transmit DPLL.
// Assumes: AHB-Lite slave, zero wait states, OKAY always; monitor fail inputs synchronous.
// Notes: Oscillator word goes out only in packet client mode.
module dmrs_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [dmrs_pkg::NUM_REFS*dmrs_pkg::NUM_MON-1:0] ref_fail,
  output logic [3:0] tracked_ref,
  output logic [1:0] loop_state,
  output logic [31:0] dco_word,
  output logic dco_soft
);
  import dmrs_pkg::*;

  logic [2:0] mode;
  logic [3:0] refsel;
  logic [3:0] fail_mask;
  logic [14:0] prio;
  logic [31:0] dco;
  logic [1:0] state;
  logic ap_write;
  logic ap_read;
  logic [9:0] ap_addr;
  logic [4:0] ref_bad;

  dmrs_sel_if sel ();
  dmrs_chooser u_chooser (.sel(sel));

  // Address phase capture
  wire take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_write <= 1'b0;
      ap_read <= 1'b0;
      ap_addr <= 10'h000;
    end else begin
      ap_write <= take && hwrite;
      ap_read <= take && !hwrite;
      ap_addr <= haddr[9:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Failure per reference from unmasked monitors
  genvar g;
  generate
    for (g = 0; g < NUM_REFS; g++) begin : g_ref
      assign ref_bad[g] = |(ref_fail[NUM_MON*g +: NUM_MON] & fail_mask);
    end
  endgenerate

  assign sel.qualified = ~ref_bad;
  assign sel.prio = prio;

  wire is_auto = mode == DMRS_AUTO;
  wire is_man = mode == DMRS_MAN_NORMAL;
  wire wr_mode = ap_write && ap_addr == ADDR_MODE;
  wire wr_refsel = ap_write && ap_addr == ADDR_REFSEL;
  wire wr_mask = ap_write && ap_addr == ADDR_FAILMASK;
  wire wr_prio = ap_write && ap_addr == ADDR_PRIO;
  wire wr_dco = ap_write && ap_addr == ADDR_DCO;
  wire [2:0] wmode = hwdata[2:0];
  wire mode_legal = wmode <= DMRS_TOP;
  wire refsel_legal = hwdata[3:0] <= REF_MAX;
  wire man_bad = (refsel > REF_MAX) || ref_bad[refsel[2:0]];
  wire [3:0] next_refsel = is_auto ? (sel.found ? sel.pick : refsel)
                         : (wr_refsel && is_man && refsel_legal) ? hwdata[3:0]
                         : refsel;

  logic [1:0] next_state;
  always_comb begin
    unique case (dmrs_mode_t'(mode))
      DMRS_MAN_NORMAL: next_state = man_bad ? DMRS_ST_HOLD : DMRS_ST_LOCK;
      DMRS_MAN_HOLD: next_state = DMRS_ST_HOLD;
      DMRS_MAN_FREE: next_state = DMRS_ST_FREE;
      DMRS_AUTO: next_state = sel.found ? DMRS_ST_LOCK : DMRS_ST_HOLD;
      DMRS_TOP: next_state = DMRS_ST_SOFT;
      default: next_state = state;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= MODE_RESET;
      refsel <= REFSEL_RESET;
      fail_mask <= FAILMASK_RESET;
      prio <= PRIO_RESET;
      dco <= DCO_RESET;
      state <= DMRS_ST_FREE;
    end else begin
      if (wr_mode && mode_legal) begin
        mode <= wmode;
      end
      refsel <= next_refsel;
      if (wr_mask) begin
        fail_mask <= hwdata[3:0];
      end
      if (wr_prio) begin
        prio <= hwdata[14:0];
      end
      if (wr_dco) begin
        dco <= hwdata;
      end
      state <= next_state;
    end
  end

  // Read data
  wire [31:0] rd_mux = (ap_addr == ADDR_MODE) ? {29'h0, mode}
                     : (ap_addr == ADDR_REFSEL) ? {28'h0, refsel}
                     : (ap_addr == ADDR_FAILMASK) ? {28'h0, fail_mask}
                     : (ap_addr == ADDR_PRIO) ? {17'h0, prio}
                     : (ap_addr == ADDR_DCO) ? dco
                     : (ap_addr == ADDR_STATUS) ? {25'h0, ref_bad, state}
                     : 32'h0000_0000;
  always_comb hrdata = ap_read ? rd_mux : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tracked_ref <= REFSEL_RESET;
      dco_word <= DCO_RESET;
      dco_soft <= 1'b0;
    end else begin
      tracked_ref <= next_refsel;
      dco_word <= (mode == DMRS_TOP) ? dco : DCO_RESET;
      dco_soft <= mode == DMRS_TOP;
    end
  end
  assign loop_state = state;

  a_auto_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    is_auto && sel.found |=> refsel == $past(sel.pick)) else $error("auto pick lost");
  a_auto_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    is_auto && !sel.found |=> state == DMRS_ST_HOLD) else $error("auto no hold");
  a_man_fail: assert property (@(posedge hclk) disable iff (!hresetn)
    is_man && man_bad |=> state == DMRS_ST_HOLD) else $error("manual no hold");
  a_man_track: assert property (@(posedge hclk) disable iff (!hresetn)
    is_man && !man_bad && !wr_refsel |=> state == DMRS_ST_LOCK && tracked_ref == refsel)
    else $error("manual no track");
  a_hold_stays: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == DMRS_MAN_HOLD ##1 mode == DMRS_MAN_HOLD |-> state == DMRS_ST_HOLD)
    else $error("holdover left");
  a_free_stays: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == DMRS_MAN_FREE |=> state == DMRS_ST_FREE) else $error("freerun left");
  a_soft_dco: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == DMRS_TOP |=> dco_soft && dco_word == $past(dco)) else $error("dco not soft");
  a_refsel_ro: assert property (@(posedge hclk) disable iff (!hresetn)
    !is_auto && !(wr_refsel && is_man) |=> $stable(refsel)) else $error("refsel changed");
  a_refsel_range: assert property (@(posedge hclk) disable iff (!hresetn)
    refsel <= REF_MAX) else $error("refsel reserved");
  a_mode_resv: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mode && !mode_legal |=> $stable(mode)) else $error("reserved mode taken");
  a_mask_only: assert property (@(posedge hclk) disable iff (!hresetn)
    fail_mask == 4'h0 && is_auto |=> state == DMRS_ST_LOCK) else $error("masked fail used");
  c_auto_switch: cover property (@(posedge hclk) disable iff (!hresetn)
    is_auto && $changed(refsel));
  c_man_hold: cover property (@(posedge hclk) disable iff (!hresetn)
    is_man && state == DMRS_ST_HOLD);
  c_top: cover property (@(posedge hclk) disable iff (!hresetn) state == DMRS_ST_SOFT);
endmodule
`default_nettype wire

// file: core/dmrs_pkg.sv
// Purpose: Constants for the DPLL mode control and reference selection block.
// Assumes: AHB-Lite register bus, 32-bit data, one register per word.
// Notes: Register indices are byte offsets divided by four.
// How it works
// - Mode 000 turns off automatic switching and tracks the reference held in the choice register.
// - In mode 000 a failure of the chosen reference puts the loop in holdover.
// - Mode 001 turns off automatic switching and stays in holdover while that code is set.
// - Mode 010 turns off automatic switching and holds the free-run state.
// - Mode 011 turns on automatic switching and locks to the highest priority qualified reference.
// - In mode 011 a failure of the tracked reference moves to the next qualified reference.
// - In mode 011 with no qualified reference left the loop enters holdover.
// - Mode 100 lets software set the oscillator control word and no reference steers it.
// - In mode 011 the choice register is read only and returns the automatic choice.
// - In mode 000 the choice register is read and written by software and is tracked.
// - Choice codes 0 to 4 name references 0 to 4 and codes 5 to 15 are reserved.
// - The choice register resets to zero so reference 0 is chosen.
// - Failure is judged only from unmasked monitor indicators, four per reference.
package dmrs_pkg;
  localparam int NUM_REFS = 5;
  localparam int NUM_MON = 4;
  localparam logic [7:0] IDX_MODE = 8'h1F;
  localparam logic [7:0] IDX_REFSEL = 8'h20;
  localparam logic [7:0] IDX_FAILMASK = 8'h21;
  localparam logic [7:0] IDX_PRIO = 8'h30;
  localparam logic [7:0] IDX_DCO = 8'h31;
  localparam logic [7:0] IDX_STATUS = 8'h32;
  localparam logic [9:0] ADDR_MODE = {IDX_MODE, 2'b00};
  localparam logic [9:0] ADDR_REFSEL = {IDX_REFSEL, 2'b00};
  localparam logic [9:0] ADDR_FAILMASK = {IDX_FAILMASK, 2'b00};
  localparam logic [9:0] ADDR_PRIO = {IDX_PRIO, 2'b00};
  localparam logic [9:0] ADDR_DCO = {IDX_DCO, 2'b00};
  localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [3:0] FAILMASK_RESET = 4'hF;
  localparam logic [3:0] REFSEL_RESET = 4'h0;
  localparam logic [3:0] REF_MAX = 4'h4;
  localparam logic [31:0] DCO_RESET = 32'h0000_0000;
  localparam logic [14:0] PRIO_RESET = 15'h4688;
  typedef enum logic [2:0] {
    DMRS_MAN_NORMAL = 3'b000,
    DMRS_MAN_HOLD = 3'b001,
    DMRS_MAN_FREE = 3'b010,
    DMRS_AUTO = 3'b011,
    DMRS_TOP = 3'b100
  } dmrs_mode_t;
  typedef enum logic [1:0] {
    DMRS_ST_FREE = 2'b00,
    DMRS_ST_LOCK = 2'b01,
    DMRS_ST_HOLD = 2'b10,
    DMRS_ST_SOFT = 2'b11
  } dmrs_state_t;
  localparam dmrs_mode_t MODE_RESET = DMRS_AUTO;
endpackage

// file: core/dmrs_sel_if.sv
`timescale 1ns/1ns
`default_nettype none
// Purpose: Carries qualification and priority into the chooser and its pick back.
// Assumes: One clock domain.
// Notes: None.
interface dmrs_sel_if;
  logic [4:0] qualified;
  logic [14:0] prio;
  logic found;
  logic [3:0] pick;
  modport top (output qualified, output prio, input found, input pick);
  modport chooser (input qualified, input prio, output found, output pick);
endinterface
`default_nettype wire

// file: core/dmrs_chooser.sv
`timescale 1ns/1ns
`default_nettype none
// Purpose: Picks the highest priority qualified reference.
// Assumes: Priority is three bits per reference, 0 is highest; ties go to the lower index.
// Notes: Purely combinational.
module dmrs_chooser (
  dmrs_sel_if.chooser sel
);
  import dmrs_pkg::*;
  always_comb begin
    logic [2:0] best;
    best = 3'h7;
    sel.found = 1'b0;
    sel.pick = 4'h0;
    for (int i = 0; i < NUM_REFS; i++) begin
      if (sel.qualified[i] && (!sel.found || sel.prio[3*i +: 3] < best)) begin
        sel.found = 1'b1;
        best = sel.prio[3*i +: 3];
        sel.pick = 4'(i);
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/dmrs_ref_model.sv
// Purpose: Five reference inputs seen through their four failure monitors.
// Assumes: Bench names the failed references and which monitor reports it.
// Notes: Fail flags are registered, so they change one clock after a request.
`timescale 1ns/1ns
`default_nettype none
module dmrs_ref_model (
  input wire logic hclk,
  input wire logic [4:0] down,
  input wire logic [1:0] mon,
  output logic [dmrs_pkg::NUM_REFS*dmrs_pkg::NUM_MON-1:0] ref_fail
);
  import dmrs_pkg::*;
  initial ref_fail = '0;
  always @(posedge hclk) begin
    for (int r = 0; r < NUM_REFS; r++) begin
      ref_fail[r*NUM_MON +: NUM_MON] <= down[r] ? (4'h1 << mon) : 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_dmrs_top.sv
// Purpose: Self-checking bench for mode control and reference choice.
// Assumes: Zero wait state slave; hready tied to hreadyout.
// Notes: Table rows cover every mode; hand tests cover refusals and reset.
`timescale 1ns/1ns
`default_nettype none
module tb_dmrs_top;
  import dmrs_pkg::*;
  typedef struct packed {
    logic [2:0] mode; logic [3:0] sel; logic [4:0] dn;
    logic [3:0] eref; logic [1:0] st; logic cref;
  } dmrs_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dco_soft;
  logic [31:0] haddr, hwdata, hrdata, dco_word, rd;
  logic [1:0] htrans, loop_state, mon;
  logic [2:0] hsize;
  logic [3:0] tracked_ref;
  logic [4:0] down;
  logic [NUM_REFS*NUM_MON-1:0] ref_fail;
  wire hready = hreadyout;
  int n_fail = 0;
  int checks_done = 0;
  dmrs_row_t rows [8] = '{
    '{3'b000, 4'h2, 5'h00, 4'h2, DMRS_ST_LOCK, 1'b1},
    '{3'b000, 4'h3, 5'h08, 4'h3, DMRS_ST_HOLD, 1'b0},
    '{3'b001, 4'h0, 5'h00, 4'h0, DMRS_ST_HOLD, 1'b0},
    '{3'b010, 4'h0, 5'h00, 4'h0, DMRS_ST_FREE, 1'b0},
    '{3'b011, 4'h0, 5'h00, 4'h0, DMRS_ST_LOCK, 1'b1},
    '{3'b011, 4'h0, 5'h01, 4'h1, DMRS_ST_LOCK, 1'b1},
    '{3'b011, 4'h0, 5'h1F, 4'h0, DMRS_ST_HOLD, 1'b0},
    '{3'b100, 4'h0, 5'h00, 4'h0, DMRS_ST_SOFT, 1'b0}};
  dmrs_top dmrs_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_fail(ref_fail),
    .tracked_ref(tracked_ref), .loop_state(loop_state), .dco_word(dco_word),
    .dco_soft(dco_soft));
  dmrs_ref_model dmrs_ref_model_inst (.hclk(hclk), .down(down), .mon(mon),
    .ref_fail(ref_fail));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ahb_wait();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      end_sim();
    end
  endtask
  // One single word transfer; read data taken at the edge ending the data phase
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, a};
    ahb_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    ahb_wait();
    rd = hrdata;
  endtask
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, mon, down, hresetn} <= '0;
    hsize <= 3'b010;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, ADDR_MODE, 32'h0);
    chk("mode reset", rd, 32'h3);
    bus(1'b0, ADDR_REFSEL, 32'h0);
    chk("refsel reset", rd, 32'h0);
    foreach (rows[i]) begin
      down <= rows[i].dn;
      mon <= 2'(i);
      bus(1'b1, ADDR_MODE, {29'h0, rows[i].mode});
      bus(1'b1, ADDR_REFSEL, {28'h0, rows[i].sel});
      bus(1'b0, ADDR_REFSEL, 32'h0);
      chk("loop_state", {30'h0, loop_state}, {30'h0, rows[i].st});
      if (rows[i].cref) begin
        chk("tracked_ref", {28'h0, tracked_ref}, {28'h0, rows[i].eref});
        chk("refsel read", rd, {28'h0, rows[i].eref});
      end
    end
    bus(1'b1, ADDR_DCO, 32'hA5C3_0F1E);
    // Word lands at the data phase edge, output register follows one edge later
    repeat (2) @(posedge hclk);
    chk("dco_word", dco_word, 32'hA5C3_0F1E);
    chk("dco_soft", {31'h0, dco_soft}, 32'h1);
    bus(1'b1, ADDR_MODE, 32'h5);
    bus(1'b0, ADDR_MODE, 32'h0);
    chk("reserved mode", rd, 32'h4);
    bus(1'b1, ADDR_MODE, 32'h3);
    down <= 5'h01;
    bus(1'b1, ADDR_FAILMASK, 32'h0);
    bus(1'b0, ADDR_REFSEL, 32'h0);
    chk("masked fail", {28'h0, tracked_ref}, 32'h0);
    chk("dco idle", dco_word, 32'h0);
    bus(1'b1, ADDR_FAILMASK, 32'hF);
    down <= 5'h00;
    bus(1'b1, ADDR_REFSEL, 32'h4);
    bus(1'b0, ADDR_REFSEL, 32'h0);
    chk("auto refsel ro", rd, 32'h0);
    bus(1'b0, ADDR_FAILMASK, 32'h0);
    chk("mask read", rd, 32'hF);
    // No qualified reference: a write must not stick while the choice is held
    down <= 5'h1F;
    bus(1'b1, ADDR_REFSEL, 32'h4);
    bus(1'b0, ADDR_REFSEL, 32'h0);
    chk("auto refsel kept", rd, 32'h0);
    chk("auto hold", {30'h0, loop_state}, {30'h0, DMRS_ST_HOLD});
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd, {25'h0, 5'h1F, DMRS_ST_HOLD});
    // Reference 3 given the best priority, all others the worst
    down <= 5'h00;
    bus(1'b1, ADDR_PRIO, 32'h71FF);
    bus(1'b0, ADDR_PRIO, 32'h0);
    chk("prio read", rd, 32'h71FF);
    chk("prio pick", {28'h0, tracked_ref}, 32'h3);
    bus(1'b1, ADDR_MODE, 32'h0);
    bus(1'b1, ADDR_REFSEL, 32'h4);
    bus(1'b1, ADDR_REFSEL, 32'h5);
    bus(1'b0, ADDR_REFSEL, 32'h0);
    chk("reserved refsel", rd, 32'h4);
    chk("manual ref4", {28'h0, tracked_ref}, 32'h4);
    bus(1'b0, 10'h3FC, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    chk("hreadyout", {31'h0, hreadyout}, 32'h1);
    hresetn <= 1'b0;
    @(posedge hclk);
    @(negedge hclk);
    chk("reset tracked", {28'h0, tracked_ref}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, ADDR_MODE, 32'h0);
    chk("mode rereset", rd, 32'h3);
    bus(1'b0, ADDR_REFSEL, 32'h0);
    chk("refsel rereset", rd, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
